//--- verif/tb_lpm_monitor.sv
// Self-checking testbench for the line power and loop closure monitor
`timescale 1ns/100ps
`default_nettype none

`define CHK(nm, e, g) \
  begin \
    check_count++; \
    if ((g) !== (e)) \
    begin \
      miscompares++; \
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g); \
    end \
  end

module tb_lpm_monitor;
  import lpm_pkg::*;

  // ----------------------------------------------------------------
  // Signals
  // ----------------------------------------------------------------
  localparam int unsigned TICK = 8;
  logic clk_i;
  logic rst_i;
  lpm_reg_req_t req;
  lpm_sample_t samp;
  logic cal_done;
  logic [7:0] rd_data_o;
  logic rd_valid_o;
  logic [2:0] linefeed_state_o;
  logic cal_override_o;
  logic irq_o;
  int miscompares = 0;
  int check_count = 0;
  logic [7:0] exp_q[$];
  logic [7:0] exp_v;
  logic [31:0] seed = 32'h056abc55;
  logic [7:0] pw;
  logic [15:0] rv;

  lpm_monitor #(.SAMPLE_CYCLES(TICK)) u_lpm_monitor (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .reg_req_i(req),
    .rd_data_o(rd_data_o),
    .rd_valid_o(rd_valid_o),
    .sample_i(samp),
    .cal_done_i(cal_done),
    .linefeed_state_o(linefeed_state_o),
    .cal_override_o(cal_override_o),
    .irq_o(irq_o)
  );

  // ----------------------------------------------------------------
  // Clock, helpers and bus tasks
  // ----------------------------------------------------------------
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction

  task automatic conclude();
    if (miscompares == 0 && check_count > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    @(posedge clk_i);
    req <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_i);
    req <= '0;
  endtask

  // Read with the expected byte noted for the watcher
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    @(posedge clk_i);
    exp_q.push_back(e);
    req <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_i);
    req <= '0;
  endtask

  // Indirect access goes through the data pair and index triggers only
  task automatic iwr(input logic [7:0] idx, input logic [15:0] v);
    wr(A_IND_LO, v[7:0]);
    wr(A_IND_HI, v[15:8]);
    wr(A_IND_WADDR, idx);
  endtask

  task automatic ird(input logic [7:0] idx, input logic [15:0] v);
    wr(A_IND_RADDR, idx);
    rd(A_IND_LO, v[7:0]);
    rd(A_IND_HI, v[15:8]);
  endtask

  task automatic ticks(input int n);
    repeat (n * TICK) @(posedge clk_i);
    #1;
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq();
    int n;
    n = 0;
    while (irq_o !== 1'b1 && n < 200)
    begin
      @(posedge clk_i);
      #1;
      n++;
    end
    if (n >= 200)
    begin
      miscompares++;
      conclude();
    end
  endtask

  // ----------------------------------------------------------------
  // Read watcher: oldest note against each answer
  // ----------------------------------------------------------------
  always @(negedge clk_i)
  begin
    if (rd_valid_o === 1'b1)
    begin
      if (exp_q.size() == 0)
      begin
        miscompares++;
        $display("CHECK FAILED read_unexpected expected %h seen %h", 8'h00, rd_data_o);
      end
      else
      begin
        // Pop once; the compare macro names its expected value twice
        exp_v = exp_q.pop_front();
        `CHK("read_data", exp_v, rd_data_o)
      end
    end
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial
  begin
    rst_i = 1'b1;
    req = '0;
    samp = '0;
    cal_done = 1'b0;
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    #1;
    `CHK("linefeed_reset", 3'h0, linefeed_state_o)
    rd(A_LINEFEED, 8'h00);
    rd(7'h7f, 8'h00);
    seed = lfsr(seed);
    rv = seed[15:0];
    iwr(I_PPT_C, rv);
    ird(I_PPT_C, rv);
    // Alarm with auto-open: pending, interrupt, line opened
    iwr(I_POLE_A, 16'h8000);
    wr(A_EN, 8'hfe);
    wr(A_AUTO_OPEN, 8'h01);
    wr(A_LINEFEED, {5'h0, LF_FWD_ACTIVE});
    seed = lfsr(seed);
    pw = seed[7:0] | 8'h01;
    @(posedge clk_i);
    samp.power[0] <= pw;
    wait_irq();
    `CHK("linefeed_auto_open", LF_OPEN, linefeed_state_o)
    rd(A_PEND, 8'h04);
    wr(A_POWER_SEL, 8'h00);
    rd(A_POWER_OUT, pw);
    wr(A_POWER_SEL, 8'h01);
    rd(A_POWER_OUT, 8'h00);
    wr(A_POWER_SEL, 8'h06);
    rd(A_POWER_OUT, 8'h00);
    @(posedge clk_i);
    samp.power[0] <= 8'h00;
    ticks(3);
    wr(A_PEND, 8'hff);
    rd(A_PEND, 8'h00);
    // Alarm without auto-open and interrupt masked
    wr(A_EN, 8'h00);
    wr(A_AUTO_OPEN, 8'h00);
    wr(A_LINEFEED, {5'h0, LF_FWD_ACTIVE});
    iwr(I_POLE_B, 16'h8000);
    @(posedge clk_i);
    samp.power[3] <= pw;
    ticks(4);
    `CHK("linefeed_kept", LF_FWD_ACTIVE, linefeed_state_o)
    `CHK("irq_masked", 1'b0, irq_o)
    rd(A_PEND, 8'h20);
    wr(A_POWER_SEL, 8'h03);
    rd(A_POWER_OUT, pw);
    @(posedge clk_i);
    samp.power[3] <= 8'h00;
    ticks(3);
    wr(A_PEND, 8'hff);
    // Loop closure on current with debounce of two intervals
    wr(A_EN, 8'h02);
    iwr(I_CLOSURE_COEF, 16'h1fff);
    iwr(I_THR_HIGH, 16'h000a);
    wr(A_DEBOUNCE, 8'h02);
    @(posedge clk_i);
    samp.lc_mag <= 6'd20;
    ticks(2);
    rd(A_CLOSURE_STAT, 8'h00);
    ticks(6);
    rd(A_CLOSURE_STAT, 8'h01);
    rd(A_PEND, 8'h02);
    #1;
    `CHK("irq_closure", 1'b1, irq_o)
    wr(A_PEND, 8'h02);
    // Hysteresis: between bounds holds, below lower leaves
    wr(A_MODE, 8'h01);
    iwr(I_THR_LOW, 16'h0005);
    @(posedge clk_i);
    samp.lc_mag <= 6'd8;
    ticks(6);
    rd(A_CLOSURE_STAT, 8'h01);
    @(posedge clk_i);
    samp.lc_mag <= 6'd2;
    ticks(6);
    rd(A_CLOSURE_STAT, 8'h00);
    // Voltage mode: threshold is a maximum voltage
    wr(A_MODE, 8'h04);
    @(posedge clk_i);
    samp.lv_mag <= 7'd20;
    ticks(6);
    rd(A_CLOSURE_STAT, 8'h00);
    @(posedge clk_i);
    samp.lv_mag <= 7'd3;
    ticks(6);
    rd(A_CLOSURE_STAT, 8'h01);
    // Open line freezes closure processing
    wr(A_LINEFEED, {5'h0, LF_OPEN});
    @(posedge clk_i);
    samp.lv_mag <= 7'd20;
    ticks(6);
    rd(A_CLOSURE_STAT, 8'h01);
    // Calibration start, override and self-clear
    wr(A_CAL, 8'h80);
    #1;
    `CHK("cal_override_on", 1'b1, cal_override_o)
    rd(A_CAL, 8'h80);
    @(posedge clk_i);
    cal_done <= 1'b1;
    @(posedge clk_i);
    cal_done <= 1'b0;
    rd(A_CAL, 8'h00);
    #1;
    `CHK("cal_override_off", 1'b0, cal_override_o)
    repeat (4) @(posedge clk_i);
    if (exp_q.size() != 0)
      miscompares++;
    conclude();
  end
endmodule

`default_nettype wire

//--- verilog/lpm_monitor.sv
// Line power alarm, loop closure detector, calibration control and register map
`timescale 1ns/100ps
`default_nettype none

module lpm_monitor #(
  parameter int unsigned SAMPLE_CYCLES = lpm_pkg::SAMPLE_CYCLES
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Register port
  input wire lpm_pkg::lpm_reg_req_t reg_req_i,
  output logic [7:0] rd_data_o,
  output logic rd_valid_o,
  // Monitor samples and calibration engine
  input wire lpm_pkg::lpm_sample_t sample_i,
  input wire logic cal_done_i,
  // Line control
  output logic [2:0] linefeed_state_o,
  output logic cal_override_o,
  output logic irq_o
);
  import lpm_pkg::*;

  localparam int unsigned TW = $clog2(SAMPLE_CYCLES);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [TW-1:0] tick_cnt_q;
  logic [7:0] en_q, ind_lo_q, ind_hi_q, ind_raddr_q, ind_waddr_q;
  logic [NUM_Q-1:0] alarm_pend_q;
  logic lc_pend_q, auto_open_on_alarm_q, cal_q, hyst_q, vmode_q, closed_q, irq_q;
  logic [2:0] lf_q, ptr_q;
  logic [6:0] closure_debounce_interval_q, db_cnt_q;
  logic [5:0] thr_hi_q, thr_lo_q;
  logic [12:0] closure_filter_coef_q;
  logic [2:0][15:0] ppt_q, nq_q;
  logic [NUM_Q-1:0][14:0] pow_y_q;
  logic [19:0] lc_y_q;
  logic [7:0] rd_data_q;
  logic rd_valid_q;

  // ----------------------------------------------------------------
  // Sample rate tick
  // ----------------------------------------------------------------
  logic tick_w;
  assign tick_w = (tick_cnt_q == TW'(SAMPLE_CYCLES - 1));

  // Free-running divider, one strobe per monitor sample
  always_ff @(posedge clk_i)
  begin
    if (rst_i || tick_w)
      tick_cnt_q <= '0;
    else
      tick_cnt_q <= tick_cnt_q + TW'(1);
  end

  // ----------------------------------------------------------------
  // Register decode
  // ----------------------------------------------------------------
  logic wr_pend, wr_en, wr_lo, wr_hi, wr_raddr, wr_waddr, wr_lf, wr_auto_open_on_alarm;
  logic wr_closure_debounce_interval, wr_ptr, wr_cal, wr_mode;
  assign wr_pend = reg_req_i.wr && (reg_req_i.addr == A_PEND);
  assign wr_en = reg_req_i.wr && (reg_req_i.addr == A_EN);
  assign wr_lo = reg_req_i.wr && (reg_req_i.addr == A_IND_LO);
  assign wr_hi = reg_req_i.wr && (reg_req_i.addr == A_IND_HI);
  assign wr_raddr = reg_req_i.wr && (reg_req_i.addr == A_IND_RADDR);
  assign wr_waddr = reg_req_i.wr && (reg_req_i.addr == A_IND_WADDR);
  assign wr_lf = reg_req_i.wr && (reg_req_i.addr == A_LINEFEED);
  assign wr_auto_open_on_alarm = reg_req_i.wr && (reg_req_i.addr == A_AUTO_OPEN);
  assign wr_closure_debounce_interval = reg_req_i.wr && (reg_req_i.addr == A_DEBOUNCE);
  assign wr_ptr = reg_req_i.wr && (reg_req_i.addr == A_POWER_SEL);
  assign wr_cal = reg_req_i.wr && (reg_req_i.addr == A_CAL);
  assign wr_mode = reg_req_i.wr && (reg_req_i.addr == A_MODE);

  // Indirect read data, selected by the address just written
  logic [7:0] isel;
  logic [15:0] ind_rdata_w, ind_wdata_w;
  assign isel = reg_req_i.wdata;
  assign ind_wdata_w = {ind_hi_q, ind_lo_q};
  assign ind_rdata_w = (isel == I_THR_HIGH) ? {10'h000, thr_hi_q} :
                       (isel == I_THR_LOW) ? {10'h000, thr_lo_q} :
                       (isel == I_PPT_A) ? ppt_q[0] :
                       (isel == I_PPT_B) ? ppt_q[1] :
                       (isel == I_PPT_C) ? ppt_q[2] :
                       (isel == I_POLE_A) ? nq_q[0] :
                       (isel == I_POLE_B) ? nq_q[1] :
                       (isel == I_POLE_C) ? nq_q[2] :
                       (isel == I_CLOSURE_COEF) ? {3'h0, closure_filter_coef_q} : 16'h0000;

  // Indirect registers; only the access window reaches them
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      thr_hi_q <= '0;
      thr_lo_q <= '0;
      ppt_q <= '0;
      nq_q <= '0;
      closure_filter_coef_q <= '0;
    end
    else if (wr_waddr)
    begin
      if (isel == I_THR_HIGH) thr_hi_q <= ind_wdata_w[5:0];
      if (isel == I_THR_LOW) thr_lo_q <= ind_wdata_w[5:0];
      if (isel == I_PPT_A) ppt_q[0] <= ind_wdata_w;
      if (isel == I_PPT_B) ppt_q[1] <= ind_wdata_w;
      if (isel == I_PPT_C) ppt_q[2] <= ind_wdata_w;
      if (isel == I_POLE_A) nq_q[0] <= ind_wdata_w;
      if (isel == I_POLE_B) nq_q[1] <= ind_wdata_w;
      if (isel == I_POLE_C) nq_q[2] <= ind_wdata_w;
      if (isel == I_CLOSURE_COEF) closure_filter_coef_q <= ind_wdata_w[12:0];
    end
  end

  // Access window: data pair and the two address triggers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      {ind_hi_q, ind_lo_q} <= '0;
      ind_raddr_q <= '0;
      ind_waddr_q <= '0;
    end
    else
    begin
      if (wr_raddr) {ind_hi_q, ind_lo_q} <= ind_rdata_w;
      else
      begin
        if (wr_lo) ind_lo_q <= reg_req_i.wdata;
        if (wr_hi) ind_hi_q <= reg_req_i.wdata;
      end
      if (wr_raddr) ind_raddr_q <= isel;
      if (wr_waddr) ind_waddr_q <= isel;
    end
  end

  // Plain direct control registers
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      en_q <= '0;
      auto_open_on_alarm_q <= 1'b0;
      closure_debounce_interval_q <= '0;
      ptr_q <= '0;
      hyst_q <= 1'b0;
      vmode_q <= 1'b0;
    end
    else
    begin
      if (wr_en) en_q <= reg_req_i.wdata & EN_MASK;
      if (wr_auto_open_on_alarm) auto_open_on_alarm_q <= reg_req_i.wdata[0];
      if (wr_closure_debounce_interval) closure_debounce_interval_q <= reg_req_i.wdata[6:0];
      if (wr_ptr) ptr_q <= reg_req_i.wdata[2:0];
      if (wr_mode) hyst_q <= reg_req_i.wdata[BIT_HYST];
      if (wr_mode) vmode_q <= reg_req_i.wdata[BIT_VMODE];
    end
  end

  // ----------------------------------------------------------------
  // Thermal filters and power alarms
  // ----------------------------------------------------------------
  logic [NUM_Q-1:0] exceed_w;
  genvar g;
  generate
    for (g = 0; g < NUM_Q; g++)
    begin : g_q
      logic signed [15:0] diff, step, sum;
      logic signed [32:0] prod;
      // Power is widened by 2^7 to line up with the threshold scale
      assign diff = $signed({1'b0, sample_i.power[g], 7'h00}) - $signed({1'b0, pow_y_q[g]});
      assign prod = diff * $signed({1'b0, nq_q[g/2]});
      assign step = prod[30:15];
      assign sum = $signed({1'b0, pow_y_q[g]}) + step;
      // Pair threshold carries that pair's own step size
      assign exceed_w[g] = {1'b0, pow_y_q[g]} > ppt_q[g/2];
      // Poles above 2^15 overshoot; software keeps them in range
      always_ff @(posedge clk_i)
      begin
        if (rst_i)
          pow_y_q[g] <= '0;
        else if (tick_w)
          pow_y_q[g] <= sum[14:0];
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Loop closure path
  // ----------------------------------------------------------------
  logic lf_allow_w, raw_w;
  logic [6:0] lc_in_w, filt_w, thr_w;
  logic signed [20:0] lc_diff, lc_step, lc_sum;
  logic signed [34:0] lc_prod;
  assign lf_allow_w = (lf_q == LF_FWD_ACTIVE) || (lf_q == LF_REV_ACTIVE) ||
                      (lf_q == LF_FWD_OHT) || (lf_q == LF_REV_OHT);
  // Magnitude only; sign is dropped for the threshold test
  assign lc_in_w = vmode_q ? sample_i.lv_mag : {1'b0, sample_i.lc_mag};
  assign lc_diff = $signed({1'b0, lc_in_w, 13'h0000}) - $signed({1'b0, lc_y_q});
  assign lc_prod = lc_diff * $signed({1'b0, closure_filter_coef_q});
  assign lc_step = lc_prod[33:13];
  assign lc_sum = $signed({1'b0, lc_y_q}) + lc_step;
  assign filt_w = lc_y_q[19:13];
  // Entry and exit bounds swap meaning between current and voltage
  assign thr_w = closed_q ? ((hyst_q && !vmode_q) ? {1'b0, thr_lo_q} : {1'b0, thr_hi_q})
                          : ((hyst_q && vmode_q) ? {1'b0, thr_lo_q} : {1'b0, thr_hi_q});
  assign raw_w = vmode_q ? (filt_w < thr_w) : (filt_w > thr_w);

  logic db_flip_w;
  assign db_flip_w = tick_w && lf_allow_w && (raw_w != closed_q) && (db_cnt_q >= closure_debounce_interval_q);

  // Filter and debounce hold still outside the allowed states
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      lc_y_q <= '0;
      db_cnt_q <= '0;
      closed_q <= 1'b0;
    end
    else if (tick_w && lf_allow_w)
    begin
      lc_y_q <= lc_sum[19:0];
      if (raw_w == closed_q)
        db_cnt_q <= '0;
      else if (db_flip_w)
      begin
        closed_q <= raw_w;
        db_cnt_q <= '0;
      end
      else
        db_cnt_q <= db_cnt_q + 7'h01;
    end
  end

  // ----------------------------------------------------------------
  // Pending flags, interrupt, linefeed and calibration
  // ----------------------------------------------------------------
  logic [NUM_Q-1:0] alarm_set_w;
  logic alarm_any_w;
  assign alarm_set_w = tick_w ? exceed_w : '0;
  assign alarm_any_w = |alarm_set_w;

  // Write one to clear; a new event in the same cycle wins
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      alarm_pend_q <= '0;
      lc_pend_q <= 1'b0;
      irq_q <= 1'b0;
    end
    else
    begin
      alarm_pend_q <= (alarm_pend_q & ~(wr_pend ? reg_req_i.wdata[7:2] : 6'h00)) | alarm_set_w;
      lc_pend_q <= (lc_pend_q & ~(wr_pend && reg_req_i.wdata[BIT_LC_IRQ])) | db_flip_w;
      irq_q <= |({alarm_pend_q, lc_pend_q} & {en_q[7:2], en_q[BIT_LC_IRQ]});
    end
  end

  // Alarm with auto-open beats a software write in the same cycle
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      lf_q <= LF_OPEN;
    else if (alarm_any_w && auto_open_on_alarm_q)
      lf_q <= LF_OPEN;
    else if (wr_lf)
      lf_q <= reg_req_i.wdata[2:0];
  end

  // Engine completion clears the start bit unless software writes it
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      cal_q <= 1'b0;
    else if (wr_cal)
      cal_q <= reg_req_i.wdata[BIT_CAL];
    else if (cal_done_i)
      cal_q <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Read path
  // ----------------------------------------------------------------
  logic [7:0] pow_read_w, rd_mux_w;
  assign pow_read_w = (ptr_q <= MAX_PTR) ? pow_y_q[ptr_q][14:7] : 8'h00;
  assign rd_mux_w = (reg_req_i.addr == A_PEND) ? {alarm_pend_q, lc_pend_q, 1'b0} :
                    (reg_req_i.addr == A_EN) ? en_q :
                    (reg_req_i.addr == A_IND_LO) ? ind_lo_q :
                    (reg_req_i.addr == A_IND_HI) ? ind_hi_q :
                    (reg_req_i.addr == A_IND_RADDR) ? ind_raddr_q :
                    (reg_req_i.addr == A_IND_WADDR) ? ind_waddr_q :
                    (reg_req_i.addr == A_LINEFEED) ? {5'h00, lf_q} :
                    (reg_req_i.addr == A_AUTO_OPEN) ? {7'h00, auto_open_on_alarm_q} :
                    (reg_req_i.addr == A_CLOSURE_STAT) ? {7'h00, closed_q} :
                    (reg_req_i.addr == A_DEBOUNCE) ? {1'b0, closure_debounce_interval_q} :
                    (reg_req_i.addr == A_POWER_SEL) ? {5'h00, ptr_q} :
                    (reg_req_i.addr == A_POWER_OUT) ? pow_read_w :
                    (reg_req_i.addr == A_CAL) ? {cal_q, 7'h00} :
                    (reg_req_i.addr == A_MODE) ? {5'h00, vmode_q, 1'b0, hyst_q} : 8'h00;

  // Registered answer, one cycle after the read strobe
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      rd_data_q <= '0;
      rd_valid_q <= 1'b0;
    end
    else
    begin
      rd_valid_q <= reg_req_i.rd;
      if (reg_req_i.rd) rd_data_q <= rd_mux_w;
    end
  end

  assign rd_data_o = rd_data_q;
  assign rd_valid_o = rd_valid_q;
  assign irq_o = irq_q;
  assign linefeed_state_o = lf_q;
  assign cal_override_o = cal_q;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  sequence s_alarm_auto;
    alarm_any_w && auto_open_on_alarm_q;
  endsequence
  sequence s_open_after;
    ##1 (lf_q == LF_OPEN) ##1 (linefeed_state_o == LF_OPEN || $past(wr_lf));
  endsequence

  a_readout_pick: assert property (@(posedge clk_i) disable iff (rst_i)
    (reg_req_i.rd && reg_req_i.addr == A_POWER_OUT && ptr_q == 3'h3) |=> rd_data_o == $past(pow_y_q[3][14:7]))
    else $error("power readout does not follow pointer");
  a_alarm_sets: assert property (@(posedge clk_i) disable iff (rst_i)
    alarm_any_w |=> ((alarm_pend_q & $past(exceed_w)) == $past(exceed_w)))
    else $error("power alarm pending not set");
  a_auto_open: assert property (@(posedge clk_i) disable iff (rst_i)
    s_alarm_auto |-> s_open_after)
    else $error("auto-open did not open the line");
  a_manual_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    (alarm_any_w && !auto_open_on_alarm_q && !wr_lf) |=> $stable(lf_q))
    else $error("manual mode changed linefeed");
  a_irq_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    (alarm_pend_q[0] && en_q[2]) |=> irq_o)
    else $error("first transistor alarm did not reach interrupt");
  a_closure_gate: assert property (@(posedge clk_i) disable iff (rst_i)
    !lf_allow_w |=> ($stable(closed_q) && $stable(lc_y_q)))
    else $error("closure path ran in a disallowed state");
  a_debounce_full: assert property (@(posedge clk_i) disable iff (rst_i)
    (closed_q != $past(closed_q)) |-> ($past(db_cnt_q) >= $past(closure_debounce_interval_q) && $past(tick_w)))
    else $error("closure changed before debounce interval");
  a_closure_pend: assert property (@(posedge clk_i) disable iff (rst_i)
    (closed_q != $past(closed_q)) |-> lc_pend_q)
    else $error("closure change without pending flag");
  a_cal_done: assert property (@(posedge clk_i) disable iff (rst_i)
    (cal_q && cal_done_i && !wr_cal) |=> !cal_q ##1 !cal_override_o || $past(wr_cal))
    else $error("calibration bit not cleared on completion");
  a_reset_open: assert property (@(posedge clk_i)
    rst_i |=> (linefeed_state_o == LF_OPEN && !irq_o))
    else $error("linefeed not open after reset");

endmodule

`default_nettype wire

//--- verilog/lpm_pkg.sv
// Shared constants and carriers for the line power and loop closure monitor
package lpm_pkg;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned SAMPLE_HZ = 800;
  localparam int unsigned SAMPLE_CYCLES = CLK_HZ / SAMPLE_HZ;

  // ----------------------------------------------------------------
  // Direct register addresses
  // ----------------------------------------------------------------
  localparam logic [6:0] A_PEND = 7'h13;
  localparam logic [6:0] A_EN = 7'h16;
  localparam logic [6:0] A_IND_LO = 7'h1c;
  localparam logic [6:0] A_IND_HI = 7'h1d;
  localparam logic [6:0] A_IND_RADDR = 7'h1e;
  localparam logic [6:0] A_IND_WADDR = 7'h1f;
  localparam logic [6:0] A_LINEFEED = 7'h40;
  localparam logic [6:0] A_AUTO_OPEN = 7'h43;
  localparam logic [6:0] A_CLOSURE_STAT = 7'h44;
  localparam logic [6:0] A_DEBOUNCE = 7'h45;
  localparam logic [6:0] A_POWER_SEL = 7'h4c;
  localparam logic [6:0] A_POWER_OUT = 7'h4d;
  localparam logic [6:0] A_CAL = 7'h60;
  localparam logic [6:0] A_MODE = 7'h6c;

  // ----------------------------------------------------------------
  // Indirect register addresses
  // ----------------------------------------------------------------
  localparam logic [7:0] I_THR_HIGH = 8'h1c;
  localparam logic [7:0] I_PPT_A = 8'h20;
  localparam logic [7:0] I_PPT_B = 8'h21;
  localparam logic [7:0] I_PPT_C = 8'h22;
  localparam logic [7:0] I_CLOSURE_COEF = 8'h23;
  localparam logic [7:0] I_POLE_A = 8'h25;
  localparam logic [7:0] I_POLE_B = 8'h26;
  localparam logic [7:0] I_POLE_C = 8'h27;
  localparam logic [7:0] I_THR_LOW = 8'h2b;

  // ----------------------------------------------------------------
  // Field positions, codes and scaling
  // ----------------------------------------------------------------
  localparam int unsigned NUM_Q = 6;
  localparam int unsigned BIT_LC_IRQ = 1;
  localparam int unsigned BIT_ALARM_LO = 2;
  localparam int unsigned BIT_CAL = 7;
  localparam int unsigned BIT_HYST = 0;
  localparam int unsigned BIT_VMODE = 2;
  localparam logic [7:0] EN_MASK = 8'hfe;
  localparam logic [2:0] LF_OPEN = 3'h0;
  localparam logic [2:0] LF_FWD_ACTIVE = 3'h1;
  localparam logic [2:0] LF_FWD_OHT = 3'h2;
  localparam logic [2:0] LF_REV_ACTIVE = 3'h5;
  localparam logic [2:0] LF_REV_OHT = 3'h6;
  localparam logic [2:0] MAX_PTR = 3'h5;
  localparam int unsigned THERMAL_SHIFT = 15;
  localparam int unsigned POWER_SHIFT = 7;
  localparam int unsigned CLOSURE_SHIFT = 13;
  localparam int unsigned POWER_STEP_AC_UW = 30400;
  localparam int unsigned POWER_STEP_B_UW = 3620;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic wr;
    logic rd;
    logic [6:0] addr;
    logic [7:0] wdata;
  } lpm_reg_req_t;

  typedef struct packed {
    logic [NUM_Q-1:0][7:0] power;
    logic lc_sign;
    logic [5:0] lc_mag;
    logic lv_sign;
    logic [6:0] lv_mag;
  } lpm_sample_t;

endpackage
